// ---- common/csm_consts.vh ----
`ifndef CSM_CONSTS_VH
`define CSM_CONSTS_VH

// ----------------------------------------
// Data space map
// ----------------------------------------
`define CSM_IO_LAST       16'h003F
`define CSM_SRAM_BASE     16'h0040
`define CSM_SRAM_LAST     16'h005F
`define CSM_DIRECT_BASE   16'h0040
`define CSM_LOCK_BASE     16'h3F00
`define CSM_LOCK_LAST     16'h3F01
`define CSM_FLASH_BASE    16'h4000
`define CSM_FLASH_LAST    16'h43FF
`define CSM_BITIO_LAST    6'h1F

// ----------------------------------------
// Sizes
// ----------------------------------------
`define CSM_PC_W          9
`define CSM_FLASH_WORDS   512
`define CSM_SRAM_BYTES    32
`define CSM_SRAM_AW       5

// ----------------------------------------
// Core registers and port-served protected registers in I/O space
// ----------------------------------------
`define CSM_REG_GUARD     6'h3C
`define CSM_REG_SPL       6'h3D
`define CSM_REG_SPH       6'h3E
`define CSM_REG_STATUS_FLAGS      6'h3F
`define CSM_REG_CLKSEL    6'h37
`define CSM_REG_CLKPRE    6'h36
`define CSM_REG_WDOG      6'h31
`define CSM_GUARD_KEY     8'hD8
`define CSM_WINDOW_CYC    3'h4
`define CSM_SP_RESET      16'h005F
`define CSM_STATUS_FLAGS_RESET    8'h00

// ----------------------------------------
// Status flag bit positions
// ----------------------------------------
`define CSM_F_I           7
`define CSM_F_T           6
`define CSM_F_H           5
`define CSM_F_S           4
`define CSM_F_V           3
`define CSM_F_N           2
`define CSM_F_Z           1
`define CSM_F_C           0
`define CSM_ALU_MASK      8'h2F

// ----------------------------------------
// Access operations and addressing modes
// ----------------------------------------
`define CSM_OP_LOAD       3'h0
`define CSM_OP_STORE      3'h1
`define CSM_OP_IN         3'h2
`define CSM_OP_OUT        3'h3
`define CSM_OP_BSET       3'h4
`define CSM_OP_BCLR       3'h5
`define CSM_OP_SKIPSET    3'h6
`define CSM_OP_SKIPCLR    3'h7
`define CSM_MODE_DIRECT   2'h0
`define CSM_MODE_IND      2'h1
`define CSM_MODE_PREDEC   2'h2
`define CSM_MODE_POSTINC  2'h3

`endif

// ---- src/csm_core.v ----
`timescale 1ns/10ps
`include "csm_consts.vh"
// Summary of operation
// RULE_01: Protected clock and watchdog writes need the unlock key written to the guard first.
// RULE_02: Key opens a four cycle window; interrupts are held off during it.
// RULE_03: After the window, interrupt service resumes and pending ones are served.
// RULE_04: Guard bit 0 reads one while window open; bits 7..1 read zero.
// RULE_05: Stack pointer is low byte 0x3D and high byte 0x3E, reset last SRAM.
// RULE_06: Global enable clears on interrupt entry, sets on return from interrupt.
// RULE_07: Global enable clear means no interrupt is taken.
// RULE_08: Set and clear interrupt instructions also drive the global enable.
// RULE_09: Bit 6 is the copy bit for bit store and bit load.
// RULE_10: Sign flag always equals negative XOR overflow.
// RULE_11: Flags H, V, N, Z, C at bits 5, 3, 2, 1, 0; all reset zero.
// RULE_12: Program memory is 512 sixteen-bit words, fetched by 9-bit counter.
// RULE_13: Program memory is readable in data space from byte address 0x4000.
// RULE_14: Stores to mapped program memory have no effect.
// RULE_15: First 64 locations are I/O, next 32 are SRAM.
// RULE_16: Lock bits and mapped flash are read-only to firmware.
// RULE_17: Direct, indirect, pre-decrement and post-increment modes; pointers updated.
// RULE_18: I/O instructions reach 64 locations; direct ones reach 0x0040..0x00BF.
// RULE_19: SRAM access completes in two clock cycles.
// RULE_20: Bit set, clear and skip work on I/O 0x00..0x1F, one bit only.
// RULE_21: Some I/O flags clear by writing one; bit ops leave them untouched.
// RULE_22: Software writes zero to reserved bits and avoids reserved addresses.
// RULE_23: Push decrements the stack pointer; stack grows downward.
// RULE_24: Protected write outside an open window is discarded.
module csm_core (
	// Clock and reset
	input  wire                    clk,
	input  wire                    rstn,
	// Data access request
	input  wire                    acc_req,
	input  wire [2:0]              acc_op,
	input  wire [1:0]              acc_mode,
	input  wire [15:0]             acc_addr,
	input  wire [7:0]              acc_wdata,
	input  wire [2:0]              acc_bit,
	input  wire [1:0]              acc_ptr_sel,
	input  wire [15:0]             ptr_in,
	// Data access answer
	output reg                     acc_done,
	output reg  [7:0]              acc_rdata,
	output reg                     skip_taken,
	output reg                     ptr_wr,
	output reg  [1:0]              ptr_wr_sel,
	output reg  [15:0]             ptr_out,
	// Core events
	input  wire                    irq_enter,
	input  wire                    return_from_irq_instr_exec,
	input  wire                    sei_exec,
	input  wire                    cli_exec,
	input  wire                    bst_exec,
	input  wire                    bst_value,
	input  wire [7:0]              alu_flag_we,
	input  wire [7:0]              alu_flags,
	input  wire                    sp_push1,
	input  wire                    sp_push2,
	input  wire                    sp_pop1,
	input  wire                    sp_pop2,
	// Core state
	output reg  [15:0]             stack_pointer,
	output reg  [7:0]              status_flags,
	output reg                     irq_allow,
	output reg                     prot_open,
	// Program memory
	input  wire [`CSM_PC_W-1:0]    program_counter,
	output reg  [15:0]             fetch_instr,
	input  wire                    prog_we,
	input  wire [`CSM_PC_W-1:0]    prog_addr,
	input  wire [15:0]             prog_wdata,
	input  wire [15:0]             lock_bits,
	// Peripheral I/O space
	output reg                     io_ext_re,
	output reg                     io_ext_we,
	output reg  [5:0]              io_ext_addr,
	output reg  [7:0]              io_ext_wdata,
	output reg  [7:0]              io_ext_wmask,
	input  wire [7:0]              io_ext_rdata
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg [15:0] flash_mem [0:`CSM_FLASH_WORDS-1];
	reg [7:0]  sram_mem  [0:`CSM_SRAM_BYTES-1];
	reg        busy;
	reg [2:0]  st_op;
	reg [15:0] st_addr;
	reg [7:0]  st_wdata;
	reg [2:0]  st_bit;
	reg [2:0]  win_cnt;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	reg [15:0] eff_addr;
	reg        is_io_op;
	reg        is_bit_op;
	reg        is_write;
	reg        is_read;
	reg        in_io;
	reg        io_internal;
	reg        io_protected;
	reg [7:0]  bit_mask;
	wire       take = acc_req & ~busy;

	always @* begin
		is_io_op  = (acc_op != `CSM_OP_LOAD) && (acc_op != `CSM_OP_STORE);
		is_bit_op = acc_op[2];
		is_write  = (acc_op == `CSM_OP_STORE) || (acc_op == `CSM_OP_OUT);
		is_read   = (acc_op == `CSM_OP_LOAD) || (acc_op == `CSM_OP_IN) ||
		            (acc_op == `CSM_OP_SKIPSET) || (acc_op == `CSM_OP_SKIPCLR);
		if (is_io_op) begin
			eff_addr = {10'h000, acc_addr[5:0]}; // [RULE_18]
		end else begin
			case (acc_mode)
				`CSM_MODE_DIRECT:  eff_addr = `CSM_DIRECT_BASE + {9'h000, acc_addr[6:0]}; // [RULE_18]
				`CSM_MODE_IND:     eff_addr = ptr_in; // [RULE_17]
				`CSM_MODE_PREDEC:  eff_addr = ptr_in - 16'h0001; // [RULE_17]
				`CSM_MODE_POSTINC: eff_addr = ptr_in; // [RULE_17]
				default:           eff_addr = ptr_in;
			endcase
		end
		in_io        = eff_addr <= `CSM_IO_LAST; // [RULE_15]
		io_internal  = eff_addr[5:0] >= `CSM_REG_GUARD;
		io_protected = (eff_addr[5:0] == `CSM_REG_CLKSEL) ||
		               (eff_addr[5:0] == `CSM_REG_CLKPRE) ||
		               (eff_addr[5:0] == `CSM_REG_WDOG);
		bit_mask     = 8'h01 << acc_bit;
	end

	// ----------------------------------------
	// Request stage and peripheral strobes
	// ----------------------------------------
	// Peripheral strobes stand one cycle; read data is sampled at the next edge.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy         <= 1'b0;
			st_op        <= 3'h0;
			st_addr      <= 16'h0000;
			st_wdata     <= 8'h00;
			st_bit       <= 3'h0;
			ptr_wr       <= 1'b0;
			ptr_wr_sel   <= 2'h0;
			ptr_out      <= 16'h0000;
			io_ext_re    <= 1'b0;
			io_ext_we    <= 1'b0;
			io_ext_addr  <= 6'h00;
			io_ext_wdata <= 8'h00;
			io_ext_wmask <= 8'h00;
		end else begin
			io_ext_re <= 1'b0;
			io_ext_we <= 1'b0;
			ptr_wr    <= 1'b0;
			if (take) begin
				busy     <= 1'b1;
				st_op    <= acc_op;
				st_addr  <= eff_addr;
				st_wdata <= acc_wdata;
				st_bit   <= acc_bit;
				if (!is_io_op && acc_mode[1]) begin
					ptr_wr     <= 1'b1; // [RULE_17]
					ptr_wr_sel <= acc_ptr_sel;
					ptr_out    <= acc_mode[0] ? ptr_in + 16'h0001 : ptr_in - 16'h0001;
				end
				if (in_io && !io_internal) begin
					io_ext_addr <= eff_addr[5:0];
					if (is_bit_op) begin
						// Bit ops beyond the low half of I/O are ignored
						if (eff_addr[5:0] <= `CSM_BITIO_LAST) begin // [RULE_20]
							io_ext_re <= acc_op[1];
							if (!acc_op[1] && (!io_protected || prot_open)) begin
								io_ext_we <= 1'b1;
							end
							// Only the named bit is in the mask, so write-one-to-clear
							// flags sharing the register are never touched.
							io_ext_wmask <= bit_mask; // [RULE_21]
							io_ext_wdata <= (acc_op == `CSM_OP_BSET) ? bit_mask : 8'h00;
						end
					end else begin
						io_ext_re    <= is_read;
						io_ext_we    <= is_write && (!io_protected || prot_open); // [RULE_01] [RULE_24]
						io_ext_wmask <= 8'hFF;
						io_ext_wdata <= acc_wdata;
					end
				end
			end else begin
				busy <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Second cycle: read mux and internal writes
	// ----------------------------------------
	reg        st_in_io;
	reg        st_in_sram;
	reg        st_in_lock;
	reg        st_in_flash;
	reg        st_write;
	reg [15:0] flash_word;
	reg [7:0]  rd_val;

	always @* begin
		st_in_io    = st_addr <= `CSM_IO_LAST;
		st_in_sram  = (st_addr >= `CSM_SRAM_BASE) && (st_addr <= `CSM_SRAM_LAST);
		st_in_lock  = (st_addr >= `CSM_LOCK_BASE) && (st_addr <= `CSM_LOCK_LAST);
		st_in_flash = (st_addr >= `CSM_FLASH_BASE) && (st_addr <= `CSM_FLASH_LAST);
		st_write    = busy && ((st_op == `CSM_OP_STORE) || (st_op == `CSM_OP_OUT));
		flash_word  = flash_mem[st_addr[`CSM_PC_W:1]]; // [RULE_13]
		rd_val      = 8'h00;
		if (st_in_io) begin
			case (st_addr[5:0])
				`CSM_REG_GUARD: rd_val = {7'h00, prot_open}; // [RULE_04]
				`CSM_REG_SPL:   rd_val = stack_pointer[7:0];
				`CSM_REG_SPH:   rd_val = stack_pointer[15:8];
				`CSM_REG_STATUS_FLAGS:  rd_val = status_flags;
				default:        rd_val = io_ext_rdata;
			endcase
		end else if (st_in_sram) begin
			rd_val = sram_mem[st_addr[`CSM_SRAM_AW-1:0]];
		end else if (st_in_lock) begin
			rd_val = st_addr[0] ? lock_bits[15:8] : lock_bits[7:0]; // [RULE_16]
		end else if (st_in_flash) begin
			rd_val = st_addr[0] ? flash_word[15:8] : flash_word[7:0];
		end
	end

	// Data answer two cycles after the request edge
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_done   <= 1'b0;
			acc_rdata  <= 8'h00;
			skip_taken <= 1'b0;
		end else begin
			acc_done   <= busy; // [RULE_19]
			skip_taken <= 1'b0;
			if (busy) begin
				acc_rdata <= rd_val;
				if (st_addr[5:0] <= `CSM_BITIO_LAST) begin // [RULE_20]
					skip_taken <= (st_op == `CSM_OP_SKIPSET && rd_val[st_bit]) ||
					              (st_op == `CSM_OP_SKIPCLR && !rd_val[st_bit]);
				end
			end
		end
	end

	// Of the memories only SRAM accepts firmware stores; lock and flash writes drop here
	always @(posedge clk) begin
		if (st_write && st_in_sram) begin // [RULE_14] [RULE_16]
			sram_mem[st_addr[`CSM_SRAM_AW-1:0]] <= st_wdata;
		end
	end

	// ----------------------------------------
	// Program memory
	// ----------------------------------------
	// Written only by the external programming port
	always @(posedge clk) begin
		if (prog_we) begin
			flash_mem[prog_addr] <= prog_wdata; // [RULE_14]
		end
		fetch_instr <= flash_mem[program_counter]; // [RULE_12]
	end

	// ----------------------------------------
	// Configuration change guard
	// ----------------------------------------
	reg       key_wr;
	reg [2:0] next_win_cnt;

	always @* begin
		key_wr = st_write && st_in_io && (st_addr[5:0] == `CSM_REG_GUARD) &&
		         (st_wdata == `CSM_GUARD_KEY);
		if (key_wr) begin
			next_win_cnt = `CSM_WINDOW_CYC; // [RULE_02]
		end else if (win_cnt != 3'h0) begin
			next_win_cnt = win_cnt - 3'h1;
		end else begin
			next_win_cnt = 3'h0;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			win_cnt   <= 3'h0;
			prot_open <= 1'b0;
		end else begin
			win_cnt   <= next_win_cnt;
			prot_open <= next_win_cnt != 3'h0; // [RULE_01] [RULE_04]
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	reg [7:0] next_status_flags;

	always @* begin
		next_status_flags = status_flags;
		if (st_write && st_in_io && (st_addr[5:0] == `CSM_REG_STATUS_FLAGS)) begin
			next_status_flags = st_wdata;
		end
		next_status_flags = (next_status_flags & ~(alu_flag_we & `CSM_ALU_MASK)) |
		            (alu_flags & alu_flag_we & `CSM_ALU_MASK); // [RULE_11]
		if (bst_exec) begin
			next_status_flags[`CSM_F_T] = bst_value; // [RULE_09]
		end
		if (cli_exec || irq_enter) begin
			next_status_flags[`CSM_F_I] = 1'b0; // [RULE_06] [RULE_08]
		end
		// Set wins if a return and an entry ever meet in one cycle
		if (sei_exec || return_from_irq_instr_exec) begin
			next_status_flags[`CSM_F_I] = 1'b1; // [RULE_06] [RULE_08]
		end
		next_status_flags[`CSM_F_S] = next_status_flags[`CSM_F_N] ^ next_status_flags[`CSM_F_V]; // [RULE_10]
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_flags <= `CSM_STATUS_FLAGS_RESET; // [RULE_11]
			irq_allow    <= 1'b0;
		end else begin
			status_flags <= next_status_flags;
			// Pending requests stay with the controller and are served once this rises
			irq_allow    <= next_status_flags[`CSM_F_I] && (next_win_cnt == 3'h0); // [RULE_02] [RULE_03] [RULE_07]
		end
	end

	// ----------------------------------------
	// Stack pointer
	// ----------------------------------------
	reg [15:0] next_sp;

	always @* begin
		next_sp = stack_pointer;
		if (sp_push1) begin
			next_sp = stack_pointer - 16'h0001; // [RULE_23]
		end else if (sp_push2) begin
			next_sp = stack_pointer - 16'h0002; // [RULE_23]
		end else if (sp_pop1) begin
			next_sp = stack_pointer + 16'h0001;
		end else if (sp_pop2) begin
			next_sp = stack_pointer + 16'h0002;
		end
		if (st_write && st_in_io && (st_addr[5:0] == `CSM_REG_SPL)) begin
			next_sp[7:0] = st_wdata; // [RULE_05]
		end
		if (st_write && st_in_io && (st_addr[5:0] == `CSM_REG_SPH)) begin
			next_sp[15:8] = st_wdata; // [RULE_05]
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stack_pointer <= `CSM_SP_RESET; // [RULE_05]
		end else begin
			stack_pointer <= next_sp;
		end
	end

endmodule // csm_core

// ---- test/csm_core_checker.sv ----
`timescale 1ns/10ps
module csm_core_checker (
	// Clock and reset
	input logic        clk,
	input logic        rstn,
	// Data access
	input logic        acc_req,
	input logic        acc_done,
	input logic        skip_taken,
	// Core events and state
	input logic        irq_enter,
	input logic        return_from_irq_instr_exec,
	input logic        sei_exec,
	input logic        sp_push1,
	input logic [15:0] stack_pointer,
	input logic [7:0]  status_flags,
	input logic        irq_allow,
	input logic        prot_open,
	// Peripheral port
	input logic        io_ext_re,
	input logic        io_ext_we,
	input logic [5:0]  io_ext_addr
);
	// ----------------------------------------
	// Take tracking
	// ----------------------------------------
	// Mirrors the one-cycle busy so a request held one cycle too long is not taken twice
	logic busy;
	logic take;
	assign take = acc_req && !busy;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			busy <= 1'b0;
		else
			busy <= take;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_done_lat; take |-> !acc_done ##1 !acc_done ##1 acc_done; endproperty
	property p_skip_done; skip_taken |-> acc_done; endproperty
	property p_sign; status_flags[4] == (status_flags[2] ^ status_flags[3]); endproperty
	property p_irq_clr; irq_enter && !sei_exec && !return_from_irq_instr_exec && !acc_req && !busy
		|=> !status_flags[7]; endproperty
	property p_return_from_irq_instr_set; return_from_irq_instr_exec |=> status_flags[7]; endproperty
	property p_win; prot_open |-> !irq_allow; endproperty
	property p_win_len; $rose(prot_open) |-> prot_open[*4] ##1 !prot_open; endproperty
	property p_gie; irq_allow |-> status_flags[7]; endproperty
	property p_push; sp_push1 && !acc_req && !busy
		|=> stack_pointer == $past(stack_pointer) - 16'h0001; endproperty
	property p_prot_wr; io_ext_we && (io_ext_addr == 6'h37 || io_ext_addr == 6'h36
		|| io_ext_addr == 6'h31) |-> $past(prot_open); endproperty
	property p_internal; io_ext_we || io_ext_re |-> io_ext_addr < 6'h3C; endproperty

	a_done_lat: assert property (p_done_lat) else $error("done not two cycles after take");
	a_skip_done: assert property (p_skip_done) else $error("skip without done");
	a_sign: assert property (p_sign) else $error("sign flag wrong");
	a_irq_clr: assert property (p_irq_clr) else $error("enable kept on entry");
	a_return_from_irq_instr_set: assert property (p_return_from_irq_instr_set) else $error("enable not set on return");
	a_win: assert property (p_win) else $error("interrupts allowed in window");
	a_win_len: assert property (p_win_len) else $error("window length wrong");
	a_gie: assert property (p_gie) else $error("allowed with enable clear");
	a_push: assert property (p_push) else $error("push did not decrement");
	a_prot_wr: assert property (p_prot_wr) else $error("locked write passed");
	a_internal: assert property (p_internal) else $error("core reg on port");

	c_take: cover property (take);
	c_win: cover property ($rose(prot_open));
	c_skip: cover property (skip_taken);
	c_push: cover property (sp_push1);
endmodule // csm_core_checker

bind csm_core csm_core_checker csm_core_checker_i (.clk(clk), .rstn(rstn), .acc_req(acc_req),
	.acc_done(acc_done), .skip_taken(skip_taken), .irq_enter(irq_enter),
	.return_from_irq_instr_exec(return_from_irq_instr_exec), .sei_exec(sei_exec), .sp_push1(sp_push1),
	.stack_pointer(stack_pointer), .status_flags(status_flags), .irq_allow(irq_allow),
	.prot_open(prot_open), .io_ext_re(io_ext_re), .io_ext_we(io_ext_we),
	.io_ext_addr(io_ext_addr));

// ---- test/test_csm_core.sv ----
`timescale 1ns/10ps
`include "csm_consts.vh"
module test_csm_core;
	// ----------------------------------------
	// Stimulus and observation
	// ----------------------------------------
	logic        clk, rstn, acc_req, prog_we;
	logic [2:0]  acc_op, acc_bit, r_str;
	logic [1:0]  acc_mode;
	logic [15:0] acc_addr, ptr_in, prog_wdata, r_mw, r_ptr;
	logic [7:0]  acc_wdata, alu_we, alu_fl, io_rdata, r_rd;
	logic [9:0]  ev;
	logic [8:0]  pc, prog_addr;
	logic        d1, r_sk;
	int          n_errors, comparisons, cyc;
	wire         acc_done, skip_taken, ptr_wr, irq_allow, prot_open, io_re, io_we;
	wire [1:0]   ptr_wr_sel;
	wire [15:0]  ptr_out, stack_pointer, fetch_instr;
	wire [7:0]   acc_rdata, status_flags, io_wdata, io_wmask;
	wire [5:0]   io_addr;

	csm_core csm_core_i (.clk(clk), .rstn(rstn), .acc_req(acc_req), .acc_op(acc_op),
		.acc_mode(acc_mode), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_bit(acc_bit),
		.acc_ptr_sel(2'h2), .ptr_in(ptr_in), .acc_done(acc_done), .acc_rdata(acc_rdata),
		.skip_taken(skip_taken), .ptr_wr(ptr_wr), .ptr_wr_sel(ptr_wr_sel), .ptr_out(ptr_out),
		.irq_enter(ev[0]), .return_from_irq_instr_exec(ev[1]), .sei_exec(ev[2]), .cli_exec(ev[3]),
		.bst_exec(ev[4]), .bst_value(alu_fl[6]), .alu_flag_we(ev[9] ? alu_we : 8'h00),
		.alu_flags(alu_fl), .sp_push1(ev[5]), .sp_push2(ev[6]), .sp_pop1(ev[7]),
		.sp_pop2(ev[8]), .stack_pointer(stack_pointer), .status_flags(status_flags),
		.irq_allow(irq_allow), .prot_open(prot_open), .program_counter(pc),
		.fetch_instr(fetch_instr), .prog_we(prog_we), .prog_addr(prog_addr),
		.prog_wdata(prog_wdata), .lock_bits(16'hA55A), .io_ext_re(io_re), .io_ext_we(io_we),
		.io_ext_addr(io_addr), .io_ext_wdata(io_wdata), .io_ext_wmask(io_wmask),
		.io_ext_rdata(io_rdata));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One access; port strobes caught in the busy cycle, done checked a cycle later
	task automatic acc(input [2:0] op, input [1:0] md, input [15:0] a, input [7:0] wd,
		input [2:0] bt, input [15:0] p);
		@(posedge clk);
		acc_req <= 1'b1;
		acc_op <= op;
		acc_mode <= md;
		acc_addr <= a;
		acc_wdata <= wd;
		acc_bit <= bt;
		ptr_in <= p;
		@(posedge clk);
		acc_req <= 1'b0;
		#1;
		d1 = acc_done;
		r_str = {ptr_wr, io_re, io_we};
		r_mw = {io_wmask, io_wdata};
		r_ptr = ptr_out;
		@(posedge clk);
		#1;
		chk({d1, acc_done}, 16'h0001);
		r_rd = acc_rdata;
		r_sk = skip_taken;
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		ev <= 10'h001 << i;
		@(posedge clk);
		ev <= 10'h000;
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		chk(stack_pointer, 16'h005F);
		acc(`CSM_OP_IN, 0, 16'h003F, 0, 0, 0); chk(r_rd, 16'h0000);
		acc(`CSM_OP_IN, 0, 16'h003E, 0, 0, 0); chk(r_rd, 16'h0000);
		acc(`CSM_OP_OUT, 0, 16'h003D, 8'h55, 0, 0); chk(r_str, 16'h0000);
		acc(`CSM_OP_IN, 0, 16'h003D, 0, 0, 0); chk(r_rd, 16'h0055);
		// Restore writes keep reserved bits zero and touch no reserved address
		acc(`CSM_OP_OUT, 0, 16'h003D, 8'h5F, 0, 0);
		// A bus write with an inconsistent sign bit must read back corrected
		acc(`CSM_OP_OUT, 0, 16'h003F, 8'h04, 0, 0);
		acc(`CSM_OP_IN, 0, 16'h003F, 0, 0, 0); chk(r_rd, 16'h0014);
		acc(`CSM_OP_OUT, 0, 16'h003F, 8'h00, 0, 0);
	endtask

	task automatic t_mem;
		acc(`CSM_OP_STORE, `CSM_MODE_DIRECT, 16'h0005, 8'hA7, 0, 0);
		acc(`CSM_OP_LOAD, `CSM_MODE_DIRECT, 16'h0005, 0, 0, 0); chk(r_rd, 16'h00A7);
		acc(`CSM_OP_STORE, `CSM_MODE_DIRECT, 16'h007F, 8'h33, 0, 0);
		acc(`CSM_OP_LOAD, `CSM_MODE_DIRECT, 16'h007F, 0, 0, 0); chk(r_rd, 16'h0000);
		acc(`CSM_OP_LOAD, `CSM_MODE_POSTINC, 0, 0, 0, 16'h0045); chk(r_rd, 16'h00A7);
		chk(r_ptr, 16'h0046);
		chk(r_str[2], 16'h0001);
		chk(ptr_wr_sel, 16'h0002);
		acc(`CSM_OP_LOAD, `CSM_MODE_PREDEC, 0, 0, 0, 16'h0046); chk(r_rd, 16'h00A7);
		chk(r_ptr, 16'h0045);
		acc(`CSM_OP_LOAD, `CSM_MODE_IND, 0, 0, 0, 16'h3F00); chk(r_rd, 16'h005A);
		acc(`CSM_OP_STORE, `CSM_MODE_IND, 0, 8'h00, 0, 16'h3F01);
		acc(`CSM_OP_LOAD, `CSM_MODE_IND, 0, 0, 0, 16'h3F01); chk(r_rd, 16'h00A5);
	endtask

	task automatic t_flash;
		@(posedge clk);
		prog_we <= 1'b1;
		prog_addr <= 9'h005;
		prog_wdata <= 16'hBEEF;
		pc <= 9'h005;
		@(posedge clk);
		prog_we <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(fetch_instr, 16'hBEEF);
		acc(`CSM_OP_LOAD, `CSM_MODE_IND, 0, 0, 0, 16'h400A); chk(r_rd, 16'h00EF);
		acc(`CSM_OP_LOAD, `CSM_MODE_IND, 0, 0, 0, 16'h400B); chk(r_rd, 16'h00BE);
		acc(`CSM_OP_STORE, `CSM_MODE_IND, 0, 8'h00, 0, 16'h400A);
		acc(`CSM_OP_LOAD, `CSM_MODE_IND, 0, 0, 0, 16'h400A); chk(r_rd, 16'h00EF);
	endtask

	// Each access is three cycles, so the second after the key lands past the window
	task automatic t_guard;
		pulse(2);
		acc(`CSM_OP_OUT, 0, 16'h003C, `CSM_GUARD_KEY, 0, 0);
		chk({prot_open, irq_allow}, 16'h0002);
		acc(`CSM_OP_IN, 0, 16'h003C, 0, 0, 0); chk({r_str, r_rd}, 16'h0001);
		acc(`CSM_OP_IN, 0, 16'h003C, 0, 0, 0); chk(r_rd, 16'h0000);
		chk(irq_allow, 16'h0001);
		acc(`CSM_OP_OUT, 0, 16'h003C, `CSM_GUARD_KEY, 0, 0);
		acc(`CSM_OP_OUT, 0, 16'h0037, 8'h5A, 0, 0); chk(r_str, 16'h0001);
		acc(`CSM_OP_OUT, 0, 16'h0036, 8'h5A, 0, 0); chk(r_str, 16'h0000);
	endtask

	task automatic t_bits;
		acc(`CSM_OP_BSET, 0, 16'h0005, 0, 3'h2, 0); chk(r_mw, 16'h0404);
		chk(r_str[0], 16'h0001);
		acc(`CSM_OP_BCLR, 0, 16'h0005, 0, 3'h3, 0); chk(r_mw, 16'h0800);
		acc(`CSM_OP_SKIPSET, 0, 16'h0005, 0, 3'h2, 0); chk(r_sk, 16'h0001);
		acc(`CSM_OP_SKIPCLR, 0, 16'h0005, 0, 3'h2, 0); chk(r_sk, 16'h0000);
		acc(`CSM_OP_SKIPCLR, 0, 16'h0005, 0, 3'h3, 0); chk(r_sk, 16'h0001);
		acc(`CSM_OP_BSET, 0, 16'h0025, 0, 3'h2, 0); chk(r_str, 16'h0000);
		acc(`CSM_OP_IN, 0, 16'h0010, 0, 0, 0); chk({r_str, r_rd}, 16'h0204);
		chk(io_addr, 16'h0010);
	endtask

	task automatic t_flags;
		pulse(0); chk({status_flags[7], irq_allow}, 16'h0000);
		pulse(1); chk({status_flags[7], irq_allow}, 16'h0003);
		pulse(3); chk({status_flags[7], irq_allow}, 16'h0000);
		// Copy value rides on flag bit 6, which the flag mask never passes
		alu_fl <= 8'h40;
		pulse(4); chk(status_flags, 16'h0040);
		alu_we <= 8'h2F;
		alu_fl <= 8'h04;
		pulse(9); chk(status_flags, 16'h0054);
		alu_fl <= 8'h2F;
		pulse(9); chk(status_flags, 16'h006F);
		pulse(4); chk(status_flags, 16'h002F);
		pulse(5); chk(stack_pointer, 16'h005E);
		pulse(6); chk(stack_pointer, 16'h005C);
		pulse(8); chk(stack_pointer, 16'h005E);
		pulse(7); chk(stack_pointer, 16'h005F);
	endtask

	task automatic finish_test;
		$display("Errors %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// The whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			finish_test();
		end
	end

	initial begin
		{rstn, acc_req, prog_we, acc_op, acc_bit, acc_mode, acc_addr, ptr_in} = '0;
		{prog_wdata, acc_wdata, alu_we, alu_fl, ev, pc, prog_addr} = '0;
		io_rdata = 8'h04;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_mem();
		t_flash();
		t_guard();
		t_bits();
		t_flags();
		finish_test();
	end
endmodule // test_csm_core
